// ---- design/sfwdg_pkg.sv ----
// Constants and types shared by the software fault watchdog design files
//
// Overview of operation
// [RULE1] The 7-bit count steps down once per 16384 clocks from a free-running prescaler.
// [RULE2] Software sets the timeout in 64 steps through the six low count bits.
// [RULE3] While active, a fall of the count from 40h to 3Fh starts a 30 us reset.
// [RULE4] The count keeps stepping down even while the watchdog is inactive.
// [RULE5] Software refreshes with a value from FFh down to C0h.
// [RULE6] Software rewrites the control register before the top count bit clears.
// [RULE7] Reset leaves the watchdog inactive; once active, only a reset deactivates it.
// [RULE8] Writing activate set with the top count bit clear forces a reset.
// [RULE9] A halt while active issues a reset instead of halting; the code does so only with the halt option set and oscillator interrupt off.
// [RULE10] Control writes never restart the prescaler, so the first step phase is unknown.
// [RULE11] Base timeout lies between (LSB+128)*64 and 16384 clocks; LSB follows timebase.
// [RULE12] Options exist for reset on halt and for an always-on hardware watchdog.
// [RULE13] With the hardware option the watchdog is always active, activate bit ignored.
// [RULE14] The control register resets to 7Fh.
// [RULE15] With oscillator interrupt enabled, halt stops the count until a wake event.
// [RULE16] The reset pulse is timed by a clock counter and released when it elapses.
`default_nettype none

package sfwdg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;

    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam logic [7:0] CTRL_RST = 8'h7f;
    localparam logic [6:0] CNT_ROLL = 7'h40;

    localparam int CFG_HALT_OPT = 0;
    localparam int CFG_HW_WDOG = 1;
    localparam int CFG_OSC_IRQ = 2;
    localparam int CFG_TB_LO = 4;
    localparam logic [5:0] CFG_RST = 6'h00;

    localparam int PRESC_DIV_DEF = 16384;
    localparam int PRESC_W = 14;
    localparam int TMIN_OFS = 128;
    localparam int TMIN_DIV = 256;
    localparam logic [7:0] LSB_TB0 = 8'h3b;
    localparam logic [7:0] LSB_TB1 = 8'h35;
    localparam logic [7:0] LSB_TB2 = 8'h23;
    localparam logic [7:0] LSB_TB3 = 8'h36;

    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_PULSE_US = 30;
    localparam int RST_CYC = (RST_PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 9;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } sfwdg_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } sfwdg_apb_rsp_t;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_AHALT} sfwdg_state_t;
endpackage

`default_nettype wire

// ---- design/sfwdg_prescaler.sv ----
// Free-running prescaler giving a one-cycle step enable for the watchdog count
`default_nettype none

module sfwdg_prescaler #(
    parameter int DIV = 16384
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    output logic TICK
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic wrap;
    logic tick_reg;

    // No clear input on purpose: register writes must not disturb the phase
    assign wrap = (cnt_reg == W'(DIV - 1));
    assign cnt_next = wrap ? '0 : cnt_reg + W'(1); // [RULE1] [RULE10]

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= wrap;
        end
    end

    assign TICK = tick_reg;
endmodule

`default_nettype wire

// ---- design/sfwdg_top.sv ----
// Software fault watchdog with APB register access and timed reset output
//
// Decided for this implementation: the placing of the registers and register access over APB.
`default_nettype none

module sfwdg_top #(
    parameter int PRESC_DIV = sfwdg_pkg::PRESC_DIV_DEF
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire sfwdg_pkg::sfwdg_apb_req_t APB_REQ,
    output var sfwdg_pkg::sfwdg_apb_rsp_t APB_RSP,
    input wire logic HALT_EXEC,
    input wire logic WAKE_IRQ,
    output logic WDOG_RST_N
);
    import sfwdg_pkg::*;

    sfwdg_apb_rsp_t rsp_reg;
    sfwdg_apb_rsp_t rsp_next;
    sfwdg_state_t state_reg;
    sfwdg_state_t state_next;

    logic act_reg;
    logic act_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [6:0] cnt_dec;
    logic halt_opt_reg;
    logic hw_reg;
    logic oie_reg;
    logic [1:0] tb_reg;
    logic [PRESC_W-1:0] since_reg;
    logic [PRESC_W-1:0] since_next;
    logic [PRESC_W-1:0] tmin0;
    logic defer_reg;
    logic defer_next;
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic [RST_CNT_W-1:0] rst_cnt_next;
    logic rst_n_reg;
    logic wake_s1_reg;
    logic wake_s2_reg;

    logic tick;
    logic setup;
    logic xfer_done;
    logic sel_ctrl;
    logic sel_cfg;
    logic sel_stat;
    logic hit;
    logic wr_ctrl;
    logic wr_cfg;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] stat_word;
    logic [7:0] lsb_val;
    logic act_eff;
    logic run;
    logic early;
    logic dec_en;
    logic busy;
    logic tmo_trig;
    logic sw_trig;
    logic halt_trig;
    logic fire;

    sfwdg_prescaler #(
        .DIV(PRESC_DIV)
    ) u_presc (
        .CORE_CLK(CORE_CLK),
        .SRST(SRST),
        .TICK(tick)
    );

    // APB slave: one wait-free access phase, answer prepared in the setup cycle
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign xfer_done = APB_REQ.psel && APB_REQ.penable && rsp_reg.pready;
    assign sel_ctrl = (APB_REQ.paddr == OFS_CTRL);
    assign sel_cfg = (APB_REQ.paddr == OFS_CFG);
    assign sel_stat = (APB_REQ.paddr == OFS_STAT);
    assign hit = sel_ctrl || sel_cfg || sel_stat;
    assign wr_ctrl = xfer_done && APB_REQ.pwrite && sel_ctrl;
    assign wr_cfg = xfer_done && APB_REQ.pwrite && sel_cfg;

    assign cfg_word = {26'h0, tb_reg, 1'b0, oie_reg, hw_reg, halt_opt_reg};
    assign stat_word = {27'h0, defer_reg, state_reg == ST_AHALT, state_reg == ST_HALT,
                        busy, act_eff};
    assign rd_data = sel_ctrl ? {24'h0, act_reg, cnt_reg} :
                     sel_cfg ? cfg_word :
                     sel_stat ? stat_word : 32'h0;

    assign rsp_next.pready = setup;
    assign rsp_next.prdata = (setup && !APB_REQ.pwrite) ? rd_data : 32'h0;
    assign rsp_next.pslverr = setup && !hit;

    // Activation is sticky; the hardware option overrides the bit entirely
    assign act_next = act_reg || (wr_ctrl && APB_REQ.pwdata[ACT_BIT]); // [RULE7]
    assign act_eff = act_reg || hw_reg; // [RULE13]

    // Shortest base timeout depends on the timebase selection
    assign lsb_val = (tb_reg == 2'h0) ? LSB_TB0 :
                     (tb_reg == 2'h1) ? LSB_TB1 :
                     (tb_reg == 2'h2) ? LSB_TB2 : LSB_TB3;
    assign tmin0 = PRESC_W'((int'(lsb_val) + TMIN_OFS) * PRESC_DIV / TMIN_DIV); // [RULE11]

    // A step that lands too soon after a write is held back until tmin0 has passed
    assign since_next = wr_ctrl ? '0 :
                        (&since_reg) ? since_reg : since_reg + PRESC_W'(1);
    assign early = (since_reg < tmin0); // [RULE11]
    assign run = (state_reg == ST_RUN);
    assign dec_en = run && !early && (tick || defer_reg); // [RULE1] [RULE4] [RULE15]
    assign defer_next = wr_ctrl ? 1'b0 :
                        (tick && early && run) ? 1'b1 :
                        dec_en ? 1'b0 : defer_reg;

    // Count runs whether or not the watchdog is active
    assign cnt_dec = cnt_reg - 7'h01;
    assign cnt_next = wr_ctrl ? APB_REQ.pwdata[6:0] : // [RULE2]
                      dec_en ? cnt_dec : cnt_reg; // [RULE4]

    // Reset sources
    assign tmo_trig = act_eff && dec_en && (cnt_reg == CNT_ROLL); // [RULE3]
    assign sw_trig = wr_ctrl && !APB_REQ.pwdata[TOP_BIT] &&
                     (APB_REQ.pwdata[ACT_BIT] || act_eff); // [RULE8]
    assign halt_trig = HALT_EXEC && run && act_eff && !oie_reg && halt_opt_reg; // [RULE9] [RULE12]
    assign busy = (rst_cnt_reg != '0);
    // A new source during a running pulse is absorbed; the pulse is not stretched
    assign fire = (tmo_trig || sw_trig || halt_trig) && !busy;
    assign rst_cnt_next = fire ? RST_CNT_W'(RST_CYC) : // [RULE16]
                          busy ? rst_cnt_reg - RST_CNT_W'(1) : '0;

    // Halt handling; wake comes from a pin and is synchronised first
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (HALT_EXEC && oie_reg) begin
                    state_next = ST_AHALT; // [RULE15]
                end else if (HALT_EXEC && !halt_trig) begin
                    state_next = ST_HALT;
                end
            end
            ST_HALT, ST_AHALT: begin
                if (wake_s2_reg) begin
                    state_next = ST_RUN; // [RULE15]
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            act_reg <= CTRL_RST[ACT_BIT]; // [RULE14]
            cnt_reg <= CTRL_RST[6:0]; // [RULE14]
            since_reg <= '1;
            defer_reg <= 1'b0;
        end else begin
            act_reg <= act_next;
            cnt_reg <= cnt_next;
            since_reg <= since_next;
            defer_reg <= defer_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            halt_opt_reg <= CFG_RST[CFG_HALT_OPT];
            hw_reg <= CFG_RST[CFG_HW_WDOG];
            oie_reg <= CFG_RST[CFG_OSC_IRQ];
            tb_reg <= CFG_RST[CFG_TB_LO+1:CFG_TB_LO];
        end else if (wr_cfg) begin
            halt_opt_reg <= APB_REQ.pwdata[CFG_HALT_OPT]; // [RULE12]
            hw_reg <= hw_reg || APB_REQ.pwdata[CFG_HW_WDOG]; // [RULE12]
            oie_reg <= APB_REQ.pwdata[CFG_OSC_IRQ];
            tb_reg <= APB_REQ.pwdata[CFG_TB_LO+1:CFG_TB_LO];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_reg <= ST_RUN;
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wake_s1_reg <= WAKE_IRQ;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rst_cnt_reg <= '0;
            rst_n_reg <= 1'b1;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            rst_n_reg <= (rst_cnt_next == '0); // [RULE3] [RULE16]
        end
    end

    assign APB_RSP = rsp_reg;
    assign WDOG_RST_N = rst_n_reg;

    // Checks
    logic [RST_CNT_W-1:0] low_len;

    always_ff @(posedge CORE_CLK) begin
        if (SRST || rst_n_reg) begin
            low_len <= '0;
        end else begin
            low_len <= low_len + RST_CNT_W'(1);
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);

    property p_ctrl_reset;
        $fell(SRST) |-> (cnt_reg == CTRL_RST[6:0]) && !act_reg && WDOG_RST_N;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not 7Fh after reset"); // [RULE14]

    property p_step;
        dec_en && !wr_ctrl |=> cnt_reg == $past(cnt_reg) - 7'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step down by one"); // [RULE1]

    property p_free_run;
        !act_eff && tick && run && !early && !wr_ctrl |=> cnt_reg != $past(cnt_reg);
    endproperty
    a_free_run: assert property (p_free_run) else $error("inactive count stopped"); // [RULE4]

    property p_timeout;
        act_eff && dec_en && cnt_reg == CNT_ROLL && !busy && !wr_ctrl
            |=> !WDOG_RST_N && cnt_reg == 7'h3f;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no reset on 40h to 3Fh"); // [RULE3]

    property p_pulse_len;
        $rose(WDOG_RST_N) |-> low_len == RST_CNT_W'(RST_CYC);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse width wrong"); // [RULE16]

    property p_act_sticky;
        act_reg |=> act_reg;
    endproperty
    a_act_sticky: assert property (p_act_sticky) else $error("activation lost without reset"); // [RULE7]

    property p_sw_reset;
        wr_ctrl && APB_REQ.pwdata[ACT_BIT] && !APB_REQ.pwdata[TOP_BIT] && !busy
            |=> !WDOG_RST_N ##1 !WDOG_RST_N;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("software reset not issued"); // [RULE8]

    property p_halt_reset;
        HALT_EXEC && run && act_eff && halt_opt_reg && !oie_reg && !busy
            |=> !WDOG_RST_N && state_reg == ST_RUN;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halt while active gave no reset"); // [RULE9]

    property p_hw_opt;
        hw_reg && !act_reg && dec_en && cnt_reg == CNT_ROLL && !busy && !wr_ctrl
            |=> !WDOG_RST_N;
    endproperty
    a_hw_opt: assert property (p_hw_opt) else $error("hardware option did not act"); // [RULE13]

    property p_ahalt_stop;
        state_reg != ST_RUN && !wr_ctrl |=> $stable(cnt_reg);
    endproperty
    a_ahalt_stop: assert property (p_ahalt_stop) else $error("count moved while halted"); // [RULE15]

    property p_min_guard;
        tick && early && run && !wr_ctrl |=> $stable(cnt_reg) && defer_reg;
    endproperty
    a_min_guard: assert property (p_min_guard) else $error("step came before tmin0"); // [RULE11]

    property p_no_restart;
        wr_ctrl |=> (u_presc.cnt_reg == '0) == $past(u_presc.wrap);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("prescaler phase disturbed"); // [RULE10]

    property p_apb_answer;
        setup |=> rsp_reg.pready ##1 !rsp_reg.pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong");

    c_sw_reset: cover property (sw_trig && !busy);
    c_timeout: cover property (tmo_trig && !busy);
    c_ahalt_wake: cover property (state_reg == ST_AHALT ##1 state_reg == ST_RUN);
    c_deferred: cover property (defer_reg && dec_en);
endmodule

`default_nettype wire

// ---- sim/test_sfwdg_top.sv ----
// Self-checking testbench for the software fault watchdog
`default_nettype none

module test_sfwdg_top;
    import sfwdg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // Short prescale keeps the run small; timing bounds scale with it
    localparam int DIV = 256;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    sfwdg_apb_req_t apb_req = '0;
    sfwdg_apb_rsp_t apb_rsp;
    logic halt_exec = 1'b0;
    logic wake_irq = 1'b0;
    logic wdog_rst_n;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    int low_cnt = 0;
    int lsb_tab [4] = '{59, 53, 35, 54};
    logic [31:0] rd;
    logic err;
    int l;

    always #50 core_clk = ~core_clk;

    sfwdg_top #(.PRESC_DIV(DIV)) sfwdg_top_i (
        .CORE_CLK(core_clk),
        .SRST(srst),
        .APB_REQ(apb_req),
        .APB_RSP(apb_rsp),
        .HALT_EXEC(halt_exec),
        .WAKE_IRQ(wake_irq),
        .WDOG_RST_N(wdog_rst_n)
    );

    always @(negedge core_clk) if (wdog_rst_n === 1'b0) low_cnt++;

    // A hang anywhere ends the run through the same report
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_in(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Response is taken at the rising edge that samples pready high, before it updates
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        chk_in("pready wait", 1, 49, n);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), exp & m, rd & m);
        chk("slverr", '0, {31'h0, err});
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
    endtask

    // Delay to the pulse is counted in half-way points after the trigger
    task automatic fire(input int max, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (wdog_rst_n !== 1'b0 && n < max);
        chk_in("delay", lo, hi, n);
        n = 0;
        while (wdog_rst_n === 1'b0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk_in("width", RST_CYC, RST_CYC, n);
    endtask

    // Status zero means the halt must reset the chip
    task automatic halt_case(input logic [31:0] cfg, input logic [31:0] stat);
        logic [31:0] q;
        do_reset();
        wr(OFS_CFG, cfg);
        wr(OFS_CTRL, 32'hff);
        @(posedge core_clk);
        halt_exec <= 1'b1;
        @(posedge core_clk);
        halt_exec <= 1'b0;
        if (stat == '0) begin
            fire(4, 1, 3);
        end else begin
            rdc(OFS_STAT, stat, 32'h0f);
            apb(1'b0, OFS_CTRL, '0);
            q = rd;
            repeat (600) @(posedge core_clk);
            apb(1'b0, OFS_CTRL, '0);
            chk("frozen", q, rd);
            wake_irq <= 1'b1;
            repeat (4) @(posedge core_clk);
            wake_irq <= 1'b0;
            repeat (600) @(posedge core_clk);
            apb(1'b0, OFS_CTRL, '0);
            chk("resumed", 32'h1, {31'h0, rd[6:0] < q[6:0]});
        end
    endtask

    initial begin
        do_reset();
        chk("rst out", 32'h1, {31'h0, wdog_rst_n});
        rdc(OFS_CTRL, {24'h0, CTRL_RST});
        rdc(OFS_CFG, 32'h0);
        rdc(OFS_STAT, 32'h0);
        apb(1'b0, 8'h0c, 32'h5a);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        repeat (280) @(posedge core_clk);
        rdc(OFS_CTRL, 32'h7e);

        // Inactive count passes through 40h without a reset
        do_reset();
        wr(OFS_CTRL, 32'h41);
        rdc(OFS_CTRL, 32'h41);
        l = low_cnt;
        repeat (800) @(posedge core_clk);
        rdc(OFS_CTRL, 32'h3e);
        chk("no reset", l, low_cnt);

        do_reset();
        wr(OFS_CTRL, 32'hc1);
        wr(OFS_CTRL, 32'h41);
        rdc(OFS_CTRL, 32'hc1);
        rdc(OFS_STAT, 32'h1, 32'h1);
        l = low_cnt;
        repeat (10) begin
            repeat (150) @(posedge core_clk);
            wr(OFS_CTRL, 32'hc1);
        end
        chk("refreshed", l, low_cnt);
        fire(600, 258, 516);

        // Tick lands early after the write, so the step waits for the minimum
        foreach (lsb_tab[i]) begin
            do_reset();
            wr(OFS_CFG, 32'(i) << CFG_TB_LO);
            repeat (200) @(posedge core_clk);
            wr(OFS_CTRL, 32'hc0);
            fire(400, lsb_tab[i] + 128, 262);
        end

        do_reset();
        wr(OFS_CTRL, 32'h80);
        fire(4, 1, 2);
        do_reset();
        wr(OFS_CTRL, 32'hff);
        wr(OFS_CTRL, 32'h3f);
        fire(4, 1, 2);

        do_reset();
        wr(OFS_CFG, 32'h02);
        wr(OFS_CFG, 32'h00);
        rdc(OFS_STAT, 32'h1, 32'h1);
        wr(OFS_CTRL, 32'h40);
        fire(400, 1, 262);

        halt_case(32'h01, 32'h0);
        halt_case(32'h00, 32'h5);
        halt_case(32'h04, 32'h9);
        conclude();
    end
endmodule

`default_nettype wire
